// ### inc/dcrm_pkg.sv
package dcrm_pkg;

  // ----------------------------------------------------------------
  // Frame and command codes
  // ----------------------------------------------------------------
  localparam int           FRAME_BITS   = 24;
  localparam logic [7:0]   ADDR_NOP     = 8'h00;
  localparam logic [7:0]   ADDR_DATA    = 8'h01;
  localparam logic [7:0]   ADDR_READ    = 8'h02;
  localparam logic [7:0]   ADDR_CONTROL = 8'h55;
  localparam logic [7:0]   ADDR_RESET   = 8'h56;
  localparam logic [7:0]   ADDR_CONFIG  = 8'h57;
  localparam logic [7:0]   ADDR_GAIN    = 8'h58;
  localparam logic [7:0]   ADDR_ZERO    = 8'h59;
  localparam logic [7:0]   ADDR_WDOG    = 8'h95;
  localparam logic [7:0]   ADDR_CRC     = 8'h96;

  // ----------------------------------------------------------------
  // Read addresses
  // ----------------------------------------------------------------
  localparam logic [1:0]   RD_STATUS    = 2'h0;
  localparam logic [1:0]   RD_DATA      = 2'h1;
  localparam logic [1:0]   RD_CONTROL   = 2'h2;
  localparam logic [5:0]   RD_CONFIG    = 6'h0b;
  localparam logic [5:0]   RD_GAIN      = 6'h13;
  localparam logic [5:0]   RD_ZERO      = 6'h17;

  // ----------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [15:0]  REG_RESET     = 16'h0000;
  localparam logic [23:0]  FRAME_RESET   = 24'h000000;
  localparam logic [15:0]  CONTROL_WMASK = 16'hfff7;
  localparam logic [15:0]  CONFIG_WMASK  = 16'h07bf;
  localparam int           RESET_BIT     = 0;

  typedef struct packed {
    logic       clearLevelChoice;
    logic       rangeExtend;
    logic       externalResistorSelect;
    logic       outputEnable;
    logic [3:0] rampTickSelect;
    logic [2:0] rampIncrementSelect;
    logic       rampLimitOn;
    logic       reservedZero;
    logic [2:0] outputRange;
  } dcrm_control_t;

  typedef struct packed {
    logic frameCheckFault;
    logic timeoutFault;
    logic currentLoopFault;
    logic rampActive;
    logic thermalFault;
  } dcrm_status_t;

endpackage : dcrm_pkg

// ### rtl/dcrm_pin_sync.sv
module dcrm_pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] stageOne;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stageOne <= '0;
      pinSync  <= '0;
    end else begin
      stageOne <= pinIn;
      pinSync  <= stageOne;
    end
  end

endmodule : dcrm_pin_sync

// ### rtl/dcrm_register_map.sv
// Overview of operation
// (RL1) Address 0x55 writes the control register.
// (RL2) Bit 15 picks the voltage clear level.
// (RL3) Bit 14 extends voltage range ten percent.
// (RL4) Bit 13 selects the external current resistor.
// (RL5) Bit 12 enables outputs, else high impedance.
// (RL6) Bits 11:8 ramp clock, ignored when ramp off.
// (RL7) Bits 7:5 ramp step, ignored when ramp off.
// (RL8) Bit 4 enables ramping, else immediate change.
// (RL9) Host writes zero to control bit 3.
// (RL10) Narrow variant: low data bits ignored, read zero.
// (RL11) Command codes store nothing.
// (RL12) Status read-only with five flags; reset write-only.
// (RL13) Read command 0x02, next frame shifts out.
// (RL14) Decode data, reset, config, trims, commands.
// (RL15) Zero trim signed; gain and data unsigned.
// (RL16) Reset returns all fields to zero.
// (RL17) Writes take effect only at the latch edge.
module dcrm_register_map #(
  parameter int DATA_BITS = 16
) (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   sclk,
  input  wire logic                   sdi,
  input  wire logic                   latch,
  input  wire dcrm_pkg::dcrm_status_t statusIn,
  output logic                        sdo,
  output dcrm_pkg::dcrm_control_t     control,
  output logic [15:0]                 configuration,
  output logic [15:0]                 outputCode,
  output logic [15:0]                 gainTrim,
  output logic signed [15:0]          offsetTrim,
  output logic                        voltagePinEnable,
  output logic                        currentPinEnable,
  output logic [3:0]                  rampTick,
  output logic [2:0]                  rampStep,
  output logic                        watchdogRestart,
  output logic                        crcFaultClear,
  output logic                        softResetPulse
);
  import dcrm_pkg::*;

  // ----------------------------------------------------------------
  // Pin sampling and edge detection
  // ----------------------------------------------------------------
  // The serial pins run on the host's clock, so all three pass the same
  // two-stage synchroniser; equal latency keeps bit and latch ordering.
  logic [2:0]  pinSync;
  logic        sclkPrev;
  logic        latchPrev;

  dcrm_pin_sync #(.WIDTH(3)) pinSyncInst (
    .clk     (clk),
    .arst_n  (arst_n),
    .pinIn   ({sclk, sdi, latch}),
    .pinSync (pinSync)
  );

  wire sclkS     = pinSync[2];
  wire sdiS      = pinSync[1];
  wire latchS    = pinSync[0];
  wire sclkRise  = sclkS & ~sclkPrev;
  wire sclkFall  = ~sclkS & sclkPrev;
  wire latchRise = latchS & ~latchPrev;

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  logic [23:0] frame;
  logic [23:0] outShift;

  wire [7:0]  addrByte = frame[23:16];
  wire [15:0] dataWord = frame[15:0];
  wire [5:0]  readAddr = frame[5:0];

  // Masks off low bits that the narrow variant does not hold.
  localparam logic [15:0] CODE_MASK = 16'(16'hffff << (16 - DATA_BITS));

  wire wrControl  = latchRise && (addrByte == ADDR_CONTROL); // [RL1] [RL17]
  wire wrData     = latchRise && (addrByte == ADDR_DATA);    // [RL14]
  wire wrConfig   = latchRise && (addrByte == ADDR_CONFIG);  // [RL14]
  wire wrGain     = latchRise && (addrByte == ADDR_GAIN);    // [RL14]
  wire wrZero     = latchRise && (addrByte == ADDR_ZERO);    // [RL14]
  wire doRead     = latchRise && (addrByte == ADDR_READ);    // [RL13]
  wire doWdog     = latchRise && (addrByte == ADDR_WDOG);    // [RL11] [RL14]
  wire doCrc      = latchRise && (addrByte == ADDR_CRC);     // [RL11] [RL14]
  // The reset register keeps nothing; only its trigger bit acts.
  wire doSoftRst  = latchRise && (addrByte == ADDR_RESET) && dataWord[RESET_BIT]; // [RL12] [RL16]

  // Reserved control bit 3 is not stored, so a careless host cannot set it.
  wire dcrm_control_t next_control = doSoftRst ? dcrm_control_t'(REG_RESET) :
                                     wrControl ? dcrm_control_t'(dataWord & CONTROL_WMASK) :
                                                 control; // [RL2] [RL3] [RL4] [RL9] [RL16]
  wire [15:0] next_config = doSoftRst ? REG_RESET : wrConfig ? (dataWord & CONFIG_WMASK) : configuration;
  wire [15:0] next_code   = doSoftRst ? REG_RESET : wrData ? (dataWord & CODE_MASK) : outputCode; // [RL10]
  wire [15:0] next_gain   = doSoftRst ? REG_RESET : wrGain ? (dataWord & CODE_MASK) : gainTrim;   // [RL10]
  wire [15:0] next_zero   = doSoftRst ? REG_RESET : wrZero ? (dataWord & CODE_MASK) : offsetTrim; // [RL15]

  // Slew fields only reach the ramp logic while ramping is on.
  wire [3:0] next_rampTick = next_control.rampLimitOn ? next_control.rampTickSelect : 4'h0;      // [RL6] [RL8]
  wire [2:0] next_rampStep = next_control.rampLimitOn ? next_control.rampIncrementSelect : 3'h0; // [RL7] [RL8]

  // ----------------------------------------------------------------
  // Readback selection
  // ----------------------------------------------------------------
  wire [15:0] statusWord = {11'h000, statusIn}; // [RL12]
  wire [15:0] readValue  = (readAddr[1:0] == RD_STATUS)  ? statusWord :
                           (readAddr[1:0] == RD_DATA)    ? outputCode :
                           (readAddr[1:0] == RD_CONTROL) ? 16'(control) :
                           (readAddr == RD_CONFIG)       ? configuration :
                           (readAddr == RD_GAIN)         ? gainTrim :
                           (readAddr == RD_ZERO)         ? offsetTrim :
                                                           REG_RESET;
  wire [23:0] next_outShift = doRead    ? {8'h00, readValue} : // [RL13]
                              latchRise ? FRAME_RESET :
                              sclkFall  ? {outShift[22:0], 1'b0} :
                                          outShift;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclkPrev  <= 1'b0;
      latchPrev <= 1'b0;
      frame     <= FRAME_RESET;
      outShift  <= FRAME_RESET;
    end else begin
      sclkPrev  <= sclkS;
      latchPrev <= latchS;
      frame     <= sclkRise ? {frame[22:0], sdiS} : frame; // [RL17]
      outShift  <= next_outShift;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      control          <= dcrm_control_t'(REG_RESET); // [RL16]
      configuration    <= REG_RESET;
      outputCode       <= REG_RESET;
      gainTrim         <= REG_RESET;
      offsetTrim       <= REG_RESET;
      voltagePinEnable <= 1'b0;
      currentPinEnable <= 1'b0;
      rampTick         <= 4'h0;
      rampStep         <= 3'h0;
    end else begin
      control          <= next_control;
      configuration    <= next_config;
      outputCode       <= next_code;
      gainTrim         <= next_gain;
      offsetTrim       <= next_zero;
      voltagePinEnable <= next_control.outputEnable; // [RL5]
      currentPinEnable <= next_control.outputEnable; // [RL5]
      rampTick         <= next_rampTick;
      rampStep         <= next_rampStep;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sdo             <= 1'b0;
      watchdogRestart <= 1'b0;
      crcFaultClear   <= 1'b0;
      softResetPulse  <= 1'b0;
    end else begin
      sdo             <= next_outShift[23]; // [RL13]
      watchdogRestart <= doWdog;            // [RL11]
      crcFaultClear   <= doCrc;             // [RL11]
      softResetPulse  <= doSoftRst;         // [RL16]
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_control_write: assert property ( // [RL1]
    wrControl && !doSoftRst |=> 16'(control) == ($past(dataWord) & CONTROL_WMASK))
    else $error("Control word not stored after write.");

  chk_clear_level: assert property ( // [RL2]
    wrControl |=> control.clearLevelChoice == $past(dataWord[15]) && control.rangeExtend == $past(dataWord[14]))
    else $error("Clear level or range extend bit wrong.");

  chk_pin_enable: assert property ( // [RL5]
    voltagePinEnable == control.outputEnable && currentPinEnable == control.outputEnable)
    else $error("Output enables disagree with control.");

  chk_ramp_gating: assert property ( // [RL8]
    !control.rampLimitOn |-> rampTick == 4'h0 && rampStep == 3'h0)
    else $error("Ramp fields leak while ramping is off.");

  chk_ramp_pass: assert property ( // [RL6]
    control.rampLimitOn |-> rampTick == control.rampTickSelect && rampStep == control.rampIncrementSelect)
    else $error("Ramp fields not passed while ramping is on.");

  chk_narrow_bits: assert property ( // [RL10]
    (outputCode & ~CODE_MASK) == 16'h0000 && (gainTrim & ~CODE_MASK) == 16'h0000)
    else $error("Unheld low bits are not zero.");

  chk_command_store: assert property ( // [RL11]
    doWdog || doCrc || doRead |=> $stable(control) && $stable(outputCode) && $stable(configuration))
    else $error("A command code changed a register.");

  chk_read_load: assert property ( // [RL13]
    doRead ##1 !latchRise |=> outShift[15:0] == $past(readValue, 2) && sdo == outShift[23])
    else $error("Read value not loaded for shifting.");

  chk_soft_reset: assert property ( // [RL16]
    doSoftRst |=> control == dcrm_control_t'(REG_RESET) && outputCode == REG_RESET && softResetPulse)
    else $error("Soft reset left a field set.");

  chk_latch_only: assert property ( // [RL17]
    !latchRise |=> $stable(control) && $stable(gainTrim) && $stable(offsetTrim))
    else $error("Register changed without a latch edge.");

  chk_data_write: assert property ( // [RL14]
    wrData |=> outputCode == ($past(dataWord) & CODE_MASK))
    else $error("Data word not stored.");

endmodule : dcrm_register_map

// ### sim/dcrm_host_model.sv
module dcrm_host_model (
  input  wire logic clk,
  input  wire logic sdo,
  output logic      sclk,
  output logic      sdi,
  output logic      latch
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Serial host
  // ----------------------------------------------------------------
  // Six clocks a phase leave margin over the two the pin synchroniser needs.
  localparam int PHASE = 6;
  initial begin
    sclk  <= 1'b0;
    sdi   <= 1'b0;
    latch <= 1'b0;
  end
  task automatic waitClk(input int n);
    repeat (n) @(posedge clk);
  endtask : waitClk
  // Bits go out MSB first; readback is sampled just before each rising edge.
  task automatic shiftBits(input logic [23:0] word, output logic [23:0] back);
    for (int i = 23; i >= 0; i--) begin
      sdi <= word[i];
      waitClk(PHASE);
      back[i] = sdo;
      sclk <= 1'b1;
      waitClk(PHASE);
      sclk <= 1'b0;
    end
    waitClk(PHASE);
    // A released data line must not look like a held bit.
    sdi <= ~word[0];
  endtask : shiftBits
  task automatic pulseLatch();
    latch <= 1'b1;
    waitClk(PHASE);
    latch <= 1'b0;
    waitClk(PHASE);
  endtask : pulseLatch
  task automatic frame(input logic [23:0] word, output logic [23:0] back);
    shiftBits(word, back);
    pulseLatch();
  endtask : frame
endmodule : dcrm_host_model

// ### sim/dcrm_register_map_bench.sv
module dcrm_register_map_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dcrm_pkg::*;
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] data;
    logic [5:0]  rd;
    logic [15:0] exp;
  } dcrm_row_t;
  // ----------------------------------------------------------------
  // Write then read back, one row each
  // ----------------------------------------------------------------
  localparam dcrm_row_t ROWS [10] = '{
    '{ADDR_CONTROL, 16'hfff7, 6'h02, 16'hfff7},
    '{ADDR_CONFIG,  16'hffff, RD_CONFIG, 16'h07bf},
    '{ADDR_DATA,    16'h1234, 6'h01, 16'h1234},
    '{ADDR_GAIN,    16'habcd, RD_GAIN, 16'habcd},
    '{ADDR_ZERO,    16'h8001, RD_ZERO, 16'h8001},
    '{ADDR_NOP,     16'hffff, 6'h3d, 16'h1234},
    '{ADDR_WDOG,    16'hffff, 6'h3e, 16'hfff7},
    '{ADDR_CRC,     16'hffff, 6'h07, 16'h0000},
    '{8'h7f,        16'hffff, 6'h00, 16'h0015},
    '{ADDR_RESET,   16'hfffe, 6'h01, 16'h1234}
  };
  logic               clk;
  logic               arst_n;
  logic               sclk;
  logic               sdi;
  logic               latch;
  logic               sdo;
  logic               vEn;
  logic               iEn;
  logic               wdog;
  logic               crcClr;
  logic               softRst;
  dcrm_status_t       statusIn;
  dcrm_control_t      control;
  logic [15:0]        configuration;
  logic [15:0]        outputCode;
  logic [15:0]        gainTrim;
  logic signed [15:0] offsetTrim;
  logic [3:0]         rampTick;
  logic [2:0]         rampStep;
  logic [23:0]        back;
  logic [15:0]        narrowCode;
  logic [15:0]        narrowGain;
  int                 failCount = 0;
  int                 nTests = 0;
  int                 wdogN = 0;
  int                 crcN = 0;
  int                 softN = 0;
  dcrm_register_map DUT (.clk(clk), .arst_n(arst_n), .sclk(sclk), .sdi(sdi), .latch(latch),
    .statusIn(statusIn), .sdo(sdo), .control(control), .configuration(configuration),
    .outputCode(outputCode), .gainTrim(gainTrim), .offsetTrim(offsetTrim), .voltagePinEnable(vEn),
    .currentPinEnable(iEn), .rampTick(rampTick), .rampStep(rampStep), .watchdogRestart(wdog),
    .crcFaultClear(crcClr), .softResetPulse(softRst));
  dcrm_host_model host (.clk(clk), .sdo(sdo), .sclk(sclk), .sdi(sdi), .latch(latch));
  // The narrow variant shares the pins, so every frame also reaches it.
  dcrm_register_map #(.DATA_BITS(12)) narrowDut (.clk(clk), .arst_n(arst_n), .sclk(sclk), .sdi(sdi),
    .latch(latch), .statusIn(statusIn), .sdo(), .control(), .configuration(), .outputCode(narrowCode),
    .gainTrim(narrowGain), .offsetTrim(), .voltagePinEnable(), .currentPinEnable(), .rampTick(),
    .rampStep(), .watchdogRestart(), .crcFaultClear(), .softResetPulse());
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    wdogN <= wdogN + int'(wdog === 1'b1);
    crcN  <= crcN + int'(crcClr === 1'b1);
    softN <= softN + int'(softRst === 1'b1);
  end
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    nTests++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  // The run needs about 10700 clocks, so this limit only trips on a hang.
  initial begin
    repeat (60000) @(posedge clk);
    failCount++;
    finish_test();
  end
  initial begin
    arst_n   <= 1'b0;
    statusIn <= 5'h15;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    check({8'h00, control}, 24'h000000);
    check({15'h0000, vEn, iEn, rampTick, rampStep}, 24'h000000);
    for (int i = 0; i < 10; i++) begin
      host.frame({ROWS[i].addr, ROWS[i].data}, back);
      host.frame({ADDR_READ, 10'h3ff, ROWS[i].rd}, back);
      host.frame(24'h000000, back);
      check(back, {8'h00, ROWS[i].exp});
    end
    check(24'(wdogN), 24'h000001);
    check(24'(crcN), 24'h000001);
    check(24'(softN), 24'h000000);
    check({8'h00, control}, 24'h00fff7);
    check({15'h0000, vEn, iEn, rampTick, rampStep}, 24'h0001ff);
    check({23'h000000, offsetTrim < 16'sh0000}, 24'h000001);
    check({8'h00, narrowCode}, 24'h001230);
    check({8'h00, narrowGain}, 24'h00abc0);
    host.shiftBits({ADDR_CONTROL, 16'h1fe7}, back);
    check({8'h00, control}, 24'h00fff7);
    host.pulseLatch();
    check({8'h00, control}, 24'h001fe7);
    check({15'h0000, vEn, iEn, rampTick, rampStep}, 24'h000180);
    host.frame({ADDR_CONTROL, 16'h0000}, back);
    check({6'h00, vEn, iEn, control}, 24'h000000);
    host.frame({ADDR_RESET, 16'h0001}, back);
    check({outputCode, 8'h00}, 24'h000000);
    check({gainTrim, configuration[7:0]}, 24'h000000);
    check({8'h00, configuration}, 24'h000000);
    check({8'h00, offsetTrim}, 24'h000000);
    check(24'(softN), 24'h000001);
    // An asynchronous reset in mid-run must clear a live control word.
    host.frame({ADDR_CONTROL, 16'h1fe7}, back);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check({6'h00, vEn, iEn, control}, 24'h000000);
    host.frame({ADDR_DATA, 16'h00a5}, back);
    check({8'h00, outputCode}, 24'h0000a5);
    check({8'h00, narrowCode}, 24'h0000a0);
    finish_test();
  end
endmodule : dcrm_register_map_bench
